// ==== dv/fw_ctrl_model.sv ====
// Purpose: Controller firmware stand-in driving event, clear-enable and mailbox lines
// Assumes: Same aclk as the register slice, no synchroniser needed
// Notes:   Drains the mailbox only when asked
`timescale 1ns/10ps
module fw_ctrl_model (
   // Clock
   input wire logic                             aclk,
   // Controller side
   output logic [mem_window_pkg::EVT_W-1:0]     soft_event_set,
   output logic [mem_window_pkg::EVT_W-1:0]     clear_enable,
   output logic                                 mailbox_write,
   output logic                                 mailbox_read
);
   // Quiet defaults; host clears allowed until firmware says otherwise
   initial begin
      soft_event_set = '0;
      clear_enable = '1;
      mailbox_write = 1'b0;
      mailbox_read = 1'b0;
   end

   // One-clock event pulse, meaning left to firmware
   task automatic fire(input logic [mem_window_pkg::EVT_W-1:0] bits);
      @(posedge aclk);
      soft_event_set <= bits;
      @(posedge aclk);
      soft_event_set <= '0;
   endtask : fire

   // Firmware mailbox write, or host drain
   task automatic mbox_post(input logic drain);
      @(posedge aclk);
      mailbox_write <= !drain;
      mailbox_read <= drain;
      @(posedge aclk);
      mailbox_write <= 1'b0;
      mailbox_read <= 1'b0;
   endtask : mbox_post

   // Guard events that must not be cleared while active
   task automatic allow_clear(input logic [mem_window_pkg::EVT_W-1:0] bits);
      @(posedge aclk);
      clear_enable <= bits;
   endtask : allow_clear
endmodule : fw_ctrl_model

// ==== dv/mem_window_regs_chk.sv ====
// Purpose: Assertions on the host memory-window register slice
// Assumes: One aclk domain, synchronous active-low reset
// Notes:   Sees top-level ports only; bound at the foot of this file
`timescale 1ns/10ps
module mem_window_regs_chk (
   // Clock and reset
   input wire logic                             aclk,
   input wire logic                             aresetn,
   // Host bus handshakes
   input wire logic                             s_axi_arready,
   input wire logic                             s_axi_rvalid,
   input wire logic                             s_axi_bvalid,
   input wire logic                             s_axi_bready,
   // Controller, memory and event side
   input wire logic [mem_window_pkg::EVT_W-1:0] soft_event_set,
   input wire logic                             mailbox_write,
   input wire logic                             mailbox_read,
   input wire mem_window_pkg::mem_req_t         mem_req,
   input wire logic [31:0]                      window_data,
   input wire logic                             host_event_irq
);
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   logic [1:0] up_d;
   logic [1:0] dn_d;

   // Recent causes; two edges cover the source register plus the output stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         up_d <= 2'h0;
         dn_d <= 2'h0;
      end else begin
         up_d <= {up_d[0], (|soft_event_set) | mailbox_write | s_axi_bvalid};
         dn_d <= {dn_d[0], s_axi_bvalid | mailbox_read};
      end
   end

   // Relations between causes and outputs
   property p_rst_clear;
      $rose(aresetn) |-> window_data == 32'h0000_0000 && !host_event_irq;
   endproperty
   a_rst_clear: assert property (p_rst_clear) else $error("state not cleared by reset");
   property p_data_cause;
      $changed(window_data) |-> $past(s_axi_bvalid);
   endproperty
   a_data_cause: assert property (p_data_cause) else $error("window data moved without a write");
   property p_read_order;
      $rose(s_axi_rvalid) |-> $past(s_axi_arready);
   endproperty
   a_read_order: assert property (p_read_order) else $error("read answer without acceptance");
   property p_resp_drop;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_resp_drop: assert property (p_resp_drop) else $error("write response not retired");
   property p_rise_cause;
      $rose(host_event_irq) |-> up_d != 2'h0;
   endproperty
   a_rise_cause: assert property (p_rise_cause) else $error("event line rose without cause");
   property p_fall_cause;
      $fell(host_event_irq) |-> dn_d != 2'h0;
   endproperty
   a_fall_cause: assert property (p_fall_cause) else $error("event line fell without host action");
   property p_mbox_line;
      mailbox_write |-> ##[1:2] host_event_irq;
   endproperty
   a_mbox_line: assert property (p_mbox_line) else $error("mailbox write missed event line");
   property p_req_pulse;
      mem_req.write |=> !mem_req.write;
   endproperty
   a_req_pulse: assert property (p_req_pulse) else $error("memory write request too long");

   // Main scenarios seen
   c_mbox: cover property (mailbox_write);
   c_irq_rise: cover property ($rose(host_event_irq));
   c_req: cover property (mem_req.write);
endmodule : mem_window_regs_chk

bind mem_window_regs mem_window_regs_chk u_chk (
   .aclk(aclk), .aresetn(aresetn), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .soft_event_set(soft_event_set),
   .mailbox_write(mailbox_write), .mailbox_read(mailbox_read), .mem_req(mem_req),
   .window_data(window_data), .host_event_irq(host_event_irq)
);

// ==== dv/tb_top.sv ====
// Purpose: Self-checking bench for the memory-window register slice
// Assumes: AXI4-Lite master tasks, firmware model on the controller side
// Notes:   Table rows cover plain register traffic; events and resets follow by hand
`timescale 1ns/10ps
module tb_top;
   typedef struct {logic [11:0] a; logic w; logic [31:0] d; logic [1:0] rsp;} row_t;
   localparam logic [1:0] OK = mem_window_pkg::RESP_OKAY;
   localparam logic [1:0] SE = mem_window_pkg::RESP_SLVERR;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid, irq, host_event_irq, mb_wr, mb_rd;
   logic [1:0] bresp, rresp, rs;
   logic [31:0] rdata, window_data, rd_data;
   logic [mem_window_pkg::EVT_W-1:0] ev_set, clr_en;
   mem_window_pkg::mem_req_t mem_req;
   int err_count = 0;
   int num_checks = 0;
   int cyc = 0;
   row_t rows[21] = '{'{12'h04C, 1, 32'h0, OK}, '{12'h010, 1, 32'h11, OK}, '{12'h014, 1, 32'h22, OK},
      '{12'h018, 1, 32'h33, OK}, '{12'h01C, 1, 32'h44, OK}, '{12'h010, 0, 32'h11, OK},
      '{12'h014, 0, 32'h22, OK}, '{12'h018, 0, 32'h33, OK}, '{12'h01C, 0, 32'h44, OK},
      '{12'h04C, 1, 32'h2, OK}, '{12'h010, 1, 32'hDEADBEEF, OK}, '{12'h010, 0, 32'hDEADBEEF, OK},
      '{12'h04C, 1, 32'h1, OK}, '{12'h010, 1, 32'h12345678, OK}, '{12'h010, 0, 32'h5678, OK},
      '{12'h04C, 1, 32'h3, OK}, '{12'h04C, 0, 32'h3, OK}, '{12'h048, 1, 32'h7, OK},
      '{12'h048, 0, 32'h7, OK}, '{12'h030, 0, 32'h0, SE}, '{12'h030, 1, 32'h0, SE}};

   mem_window_regs u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .soft_event_set(ev_set),
      .clear_enable(clr_en), .mailbox_write(mb_wr), .mailbox_read(mb_rd), .mem_req(mem_req),
      .window_data(window_data), .host_event_irq(host_event_irq), .irq(irq));
   fw_ctrl_model u_fw (.aclk(aclk), .soft_event_set(ev_set), .clear_enable(clr_en),
      .mailbox_write(mb_wr), .mailbox_read(mb_rd));

   // Clock and hang guard; the whole run needs well under a thousand cycles
   always #5 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         err_count++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      if (err_count == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk

   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            done = 1'b1;
            rs = bresp;
            bready <= 1'b0;
         end
      end
   endtask : wr

   task automatic rd_reg(input logic [11:0] a);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            done = 1'b1;
            rd_data = rdata;
            rs = rresp;
            rready <= 1'b0;
         end
      end
   endtask : rd_reg

   // Main sequence: reset values, table, then events, interrupts and a second reset
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         rd_reg(12'h010 + 12'(4 * i));
         chk("reset value", rd_data, 32'h0);
      end
      foreach (rows[i]) begin
         if (rows[i].w) begin
            wr(rows[i].a, rows[i].d);
         end else begin
            rd_reg(rows[i].a);
            chk("read data", rd_data, rows[i].d);
         end
         chk("response", 32'(rs), 32'(rows[i].rsp));
      end
      chk("window data", window_data, 32'hDEAD_5678);
      chk("auto increment", 32'({mem_req.auto_inc, mem_req.width}), 32'h7);
      u_fw.fire(15'h7FFF);
      repeat (2) @(posedge aclk);
      chk("masked event line", 32'(host_event_irq), 32'h0);
      rd_reg(12'h020);
      chk("source low", rd_data, 32'hFE);
      rd_reg(12'h024);
      chk("source high", rd_data, 32'hFF);
      u_fw.allow_clear(15'h7F55);
      wr(12'h020, 32'hFF);
      wr(12'h024, 32'h0F);
      rd_reg(12'h020);
      chk("guarded clear", rd_data, 32'h54);
      rd_reg(12'h024);
      chk("partial clear", rd_data, 32'hF1);
      wr(12'h02C, 32'h80);
      repeat (2) @(posedge aclk);
      chk("unmasked event line", 32'(host_event_irq), 32'h1);
      wr(12'h02C, 32'h0);
      wr(12'h048, 32'h0);
      wr(12'h044, 32'h7);
      u_fw.mbox_post(1'b0);
      repeat (2) @(posedge aclk);
      chk("mailbox event line", 32'(host_event_irq), 32'h1);
      chk("disabled irq", 32'(irq), 32'h0);
      wr(12'h020, 32'h01);
      rd_reg(12'h020);
      chk("mailbox flag", rd_data, 32'h55);
      rd_reg(12'h040);
      chk("irq status", rd_data, 32'h2);
      wr(12'h048, 32'h2);
      repeat (2) @(posedge aclk);
      chk("enabled irq", 32'(irq), 32'h1);
      wr(12'h044, 32'h2);
      repeat (2) @(posedge aclk);
      chk("cleared irq", 32'(irq), 32'h0);
      u_fw.mbox_post(1'b1);
      rd_reg(12'h020);
      chk("drained", rd_data, 32'h54);
      aresetn <= 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk("data after reset", window_data, 32'h0);
      chk("event line after reset", 32'(host_event_irq), 32'h0);
      rd_reg(12'h020);
      chk("source after reset", rd_data, 32'h0);
      tally_and_finish();
   end
endmodule : tb_top

// ==== src/mem_window_pkg.sv ====
// Purpose: Shared constants and types for the host memory-window register slice
// Assumes: AXI4-Lite, 32-bit data, one register per aligned word (byte address = index * 4)
// Notes:   Indices are word indices, compared against address bits [11:2]
package mem_window_pkg;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned IDX_W  = 10;
   localparam int unsigned EVT_W  = 15;
   localparam int unsigned IRQ_W  = 3;

   // Register indices
   localparam logic [IDX_W-1:0] IDX_DATA_B0    = 10'h004;
   localparam logic [IDX_W-1:0] IDX_DATA_B1    = 10'h005;
   localparam logic [IDX_W-1:0] IDX_DATA_B2    = 10'h006;
   localparam logic [IDX_W-1:0] IDX_DATA_B3    = 10'h007;
   localparam logic [IDX_W-1:0] IDX_SRC_LOW    = 10'h008;
   localparam logic [IDX_W-1:0] IDX_SRC_HIGH   = 10'h009;
   localparam logic [IDX_W-1:0] IDX_MASK_LOW   = 10'h00A;
   localparam logic [IDX_W-1:0] IDX_MASK_HIGH  = 10'h00B;
   localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h010;
   localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR  = 10'h011;
   localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 10'h012;
   localparam logic [IDX_W-1:0] IDX_ACCESS     = 10'h013;

   // Reset values
   localparam logic [31:0]      DATA_RESET  = 32'h0000_0000;
   localparam logic [EVT_W-1:0] EVT_RESET   = 15'h0000;
   localparam logic [IRQ_W-1:0] IRQ_RESET   = 3'h0;
   localparam logic [1:0]       ACC_RESET   = 2'h0;

   // Field positions of the interrupt status register
   localparam int unsigned IRQ_BIT_CLEARED = 0;
   localparam int unsigned IRQ_BIT_MAILBOX = 1;
   localparam int unsigned IRQ_BIT_ACCESS  = 2;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Access width selection for the data register
   typedef enum logic [1:0] {
      ACC_BYTE    = 2'h0,
      ACC_HALF    = 2'h1,
      ACC_WORD    = 2'h2,
      ACC_WORD_AI = 2'h3
   } access_type_t;

   // Request handed to the memory side on a window access
   typedef struct packed {
      logic         write;
      logic         read;
      logic         auto_inc;
      access_type_t width;
   } mem_req_t;
endpackage : mem_window_pkg

// ==== src/mem_window_regs.sv ====
// Purpose: Host register slice of an embedded memory window: data bytes and event sources
// Assumes: Controller-side inputs come from logic on aclk; host reaches registers over AXI4-Lite
// Notes:   Width-dependent accesses apply at the low data byte only
//
// What this block does
// R1 - The low byte of the 32-bit window data sits at offset 04h, host read/write.
// R2 - Data bits 15:8 sit at offset 05h and bits 23:16 at offset 06h, both read/write.
// R3 - The high byte of the window data sits at offset 07h, host read/write.
// R4 - Seven firmware event bits live in bits 7:1 of the low source register at 08h.
// R5 - Eight more firmware event bits live in bits 7:0 of the high source register at 09h.
// R6 - Controller firmware may set any event bit; its meaning is up to firmware.
// R7 - A host write of one clears an event bit, a zero leaves it alone.
// R8 - A host clear is ignored where the controller's clear-enable bit is zero.
// R9 - Bit 0 of the low source register is set whenever the controller writes its mailbox.
// R10 - The mailbox flag has no mask bit; only event bits have mask positions.
// R11 - The host event line rises for an event bit only when its mask bit is one.
// R12 - The data access width follows the access type: byte, halfword, word, word with increment.
// R13 - System reset clears the data bytes, the event bits and the mailbox flag.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/10ps
module mem_window_regs (
   // Clock and reset
   input  wire logic                                     aclk,
   input  wire logic                                     aresetn,
   // AXI4-Lite write address and data
   input  wire logic [mem_window_pkg::ADDR_W-1:0]        s_axi_awaddr,
   input  wire logic                                     s_axi_awvalid,
   output logic                                          s_axi_awready,
   input  wire logic [31:0]                              s_axi_wdata,
   input  wire logic [3:0]                               s_axi_wstrb,
   input  wire logic                                     s_axi_wvalid,
   output logic                                          s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                                    s_axi_bresp,
   output logic                                          s_axi_bvalid,
   input  wire logic                                     s_axi_bready,
   // AXI4-Lite read
   input  wire logic [mem_window_pkg::ADDR_W-1:0]        s_axi_araddr,
   input  wire logic                                     s_axi_arvalid,
   output logic                                          s_axi_arready,
   output logic [31:0]                                   s_axi_rdata,
   output logic [1:0]                                    s_axi_rresp,
   output logic                                          s_axi_rvalid,
   input  wire logic                                     s_axi_rready,
   // Controller side
   input  wire logic [mem_window_pkg::EVT_W-1:0]         soft_event_set,
   input  wire logic [mem_window_pkg::EVT_W-1:0]         clear_enable,
   input  wire logic                                     mailbox_write,
   input  wire logic                                     mailbox_read,
   // Memory side
   output mem_window_pkg::mem_req_t                      mem_req,
   output logic [31:0]                                   window_data,
   // Interrupts
   output logic                                          host_event_irq,
   output logic                                          irq
);
   // Registers
   logic [7:0]                          window_data_lsb;
   logic [7:0]                          window_data_b1;
   logic [7:0]                          window_data_b2;
   logic [7:0]                          window_data_msb;
   logic [mem_window_pkg::EVT_W-1:0]    soft_event_reg;
   logic [mem_window_pkg::EVT_W-1:0]    soft_event_mask_reg;
   logic                                mailbox_written_flag;
   mem_window_pkg::access_type_t        access_type_reg;
   logic [mem_window_pkg::IRQ_W-1:0]    irq_status_reg;
   logic [mem_window_pkg::IRQ_W-1:0]    irq_enable_reg;
   // AXI holding state
   logic                                aw_held_reg;
   logic                                w_held_reg;
   logic [mem_window_pkg::IDX_W-1:0]    aw_idx_reg;
   logic [31:0]                         wdata_reg;
   logic [3:0]                          wstrb_reg;
   // Decoded write and read
   logic                                wr_fire;
   logic [mem_window_pkg::IDX_W-1:0]    rd_idx;
   logic                                rd_fire;
   logic [mem_window_pkg::EVT_W-1:0]    host_clear;
   logic [mem_window_pkg::EVT_W-1:0]    clear_taken;
   logic [mem_window_pkg::IRQ_W-1:0]    irq_event;
   logic [31:0]                         rd_value;
   logic                                rd_hit;

   // True when the index names a register of this block
   function automatic logic idx_mapped(input logic [mem_window_pkg::IDX_W-1:0] idx);
      idx_mapped = (idx >= mem_window_pkg::IDX_DATA_B0 && idx <= mem_window_pkg::IDX_MASK_HIGH)
                || (idx >= mem_window_pkg::IDX_IRQ_STATUS && idx <= mem_window_pkg::IDX_ACCESS);
   endfunction : idx_mapped

   // Write fires once both address and data are held, response channel free
   assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
   assign rd_fire = s_axi_arvalid && s_axi_arready;
   assign rd_idx  = s_axi_araddr[mem_window_pkg::ADDR_W-1:2];

   // Address and data channels accepted in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg   <= 1'b0;
         w_held_reg    <= 1'b0;
         aw_idx_reg    <= '0;
         wdata_reg     <= 32'h0000_0000;
         wstrb_reg     <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_idx_reg  <= s_axi_awaddr[mem_window_pkg::ADDR_W-1:2];
         end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held_reg <= 1'b0;
         end
      end
   end

   // Write response; unmapped indices answer SLVERR
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= mem_window_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= idx_mapped(aw_idx_reg) ? mem_window_pkg::RESP_OKAY : mem_window_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Window data bytes; a low-byte write takes the width of the access type
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         window_data_lsb <= mem_window_pkg::DATA_RESET[7:0];   // [R13]
         window_data_b1  <= mem_window_pkg::DATA_RESET[15:8];
         window_data_b2  <= mem_window_pkg::DATA_RESET[23:16];
         window_data_msb <= mem_window_pkg::DATA_RESET[31:24];
      end else if (wr_fire) begin
         if (aw_idx_reg == mem_window_pkg::IDX_DATA_B0) begin
            if (wstrb_reg[0])
               window_data_lsb <= wdata_reg[7:0];   // [R1]
            if (access_type_reg != mem_window_pkg::ACC_BYTE && wstrb_reg[1])
               window_data_b1 <= wdata_reg[15:8];   // [R12]
            if (access_type_reg[1] && wstrb_reg[2])
               window_data_b2 <= wdata_reg[23:16];  // [R12]
            if (access_type_reg[1] && wstrb_reg[3])
               window_data_msb <= wdata_reg[31:24]; // [R12]
         end
         if (aw_idx_reg == mem_window_pkg::IDX_DATA_B1 && wstrb_reg[0])
            window_data_b1 <= wdata_reg[7:0];       // [R2]
         if (aw_idx_reg == mem_window_pkg::IDX_DATA_B2 && wstrb_reg[0])
            window_data_b2 <= wdata_reg[7:0];       // [R2]
         if (aw_idx_reg == mem_window_pkg::IDX_DATA_B3 && wstrb_reg[0])
            window_data_msb <= wdata_reg[7:0];      // [R3]
      end
   end

   // Host write-one clears, gated by the controller's clear enables
   always_comb begin
      host_clear = '0;
      if (wr_fire && aw_idx_reg == mem_window_pkg::IDX_SRC_LOW && wstrb_reg[0])
         host_clear[6:0] = wdata_reg[7:1];          // [R4] [R7]
      if (wr_fire && aw_idx_reg == mem_window_pkg::IDX_SRC_HIGH && wstrb_reg[0])
         host_clear[14:7] = wdata_reg[7:0];         // [R5] [R7]
      clear_taken = host_clear & clear_enable & soft_event_reg; // [R8]
   end

   // Event bits: a firmware set wins over a host clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn)
         soft_event_reg <= mem_window_pkg::EVT_RESET;                          // [R13]
      else
         soft_event_reg <= (soft_event_reg & ~clear_taken) | soft_event_set;   // [R6] [R7] [R8]
   end

   // Mailbox flag: set by a controller mailbox write, cleared when the host drains the mailbox
   always_ff @(posedge aclk) begin
      if (!aresetn)
         mailbox_written_flag <= 1'b0;              // [R13]
      else if (mailbox_write)
         mailbox_written_flag <= 1'b1;              // [R9]
      else if (mailbox_read)
         mailbox_written_flag <= 1'b0;
   end

   // Mask and access-type registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         soft_event_mask_reg <= mem_window_pkg::EVT_RESET;
         access_type_reg     <= mem_window_pkg::access_type_t'(mem_window_pkg::ACC_RESET);
      end else if (wr_fire && wstrb_reg[0]) begin
         if (aw_idx_reg == mem_window_pkg::IDX_MASK_LOW)
            soft_event_mask_reg[6:0] <= wdata_reg[7:1];  // Bit 0 has no mask: [R10]
         if (aw_idx_reg == mem_window_pkg::IDX_MASK_HIGH)
            soft_event_mask_reg[14:7] <= wdata_reg[7:0];
         if (aw_idx_reg == mem_window_pkg::IDX_ACCESS)
            access_type_reg <= mem_window_pkg::access_type_t'(wdata_reg[1:0]); // [R12]
      end
   end

   // Host event line; the mailbox flag raises it without any mask
   always_ff @(posedge aclk) begin
      if (!aresetn)
         host_event_irq <= 1'b0;
      else
         host_event_irq <= |(soft_event_reg & soft_event_mask_reg) | mailbox_written_flag; // [R11] [R10]
   end

   // Memory request pulse on a low-byte data access
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mem_req     <= '0;
         window_data <= mem_window_pkg::DATA_RESET;
      end else begin
         mem_req.write    <= wr_fire && aw_idx_reg == mem_window_pkg::IDX_DATA_B0;
         mem_req.read     <= rd_fire && rd_idx == mem_window_pkg::IDX_DATA_B0;
         mem_req.auto_inc <= access_type_reg == mem_window_pkg::ACC_WORD_AI;        // [R12]
         mem_req.width    <= access_type_reg;
         window_data      <= {window_data_msb, window_data_b2, window_data_b1, window_data_lsb};
      end
   end

   // Block interrupt events
   assign irq_event = {mem_req.write | mem_req.read, mailbox_write, |clear_taken};

   // Sticky status, write-one clear; a new event wins over its clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status_reg <= mem_window_pkg::IRQ_RESET;
         irq_enable_reg <= mem_window_pkg::IRQ_RESET;
         irq            <= 1'b0;
      end else begin
         if (wr_fire && aw_idx_reg == mem_window_pkg::IDX_IRQ_CLEAR && wstrb_reg[0])
            irq_status_reg <= (irq_status_reg & ~wdata_reg[mem_window_pkg::IRQ_W-1:0]) | irq_event;
         else
            irq_status_reg <= irq_status_reg | irq_event;
         if (wr_fire && aw_idx_reg == mem_window_pkg::IDX_IRQ_ENABLE && wstrb_reg[0])
            irq_enable_reg <= wdata_reg[mem_window_pkg::IRQ_W-1:0];
         irq <= |(irq_status_reg & irq_enable_reg);
      end
   end

   // Read mux; the low data byte returns as many bytes as the access width
   always_comb begin
      rd_value = 32'h0000_0000;
      rd_hit   = idx_mapped(rd_idx);
      unique case (rd_idx)
         mem_window_pkg::IDX_DATA_B0: begin
            unique case (access_type_reg)
               mem_window_pkg::ACC_BYTE: rd_value = {24'h00_0000, window_data_lsb};          // [R1]
               mem_window_pkg::ACC_HALF: rd_value = {16'h0000, window_data_b1, window_data_lsb}; // [R12]
               mem_window_pkg::ACC_WORD,
               mem_window_pkg::ACC_WORD_AI: rd_value = {window_data_msb, window_data_b2,
                                                        window_data_b1, window_data_lsb};     // [R12]
            endcase
         end
         mem_window_pkg::IDX_DATA_B1:    rd_value = {24'h00_0000, window_data_b1};          // [R2]
         mem_window_pkg::IDX_DATA_B2:    rd_value = {24'h00_0000, window_data_b2};          // [R2]
         mem_window_pkg::IDX_DATA_B3:    rd_value = {24'h00_0000, window_data_msb};         // [R3]
         mem_window_pkg::IDX_SRC_LOW:    rd_value = {24'h00_0000, soft_event_reg[6:0], mailbox_written_flag}; // [R4] [R9]
         mem_window_pkg::IDX_SRC_HIGH:   rd_value = {24'h00_0000, soft_event_reg[14:7]};    // [R5]
         mem_window_pkg::IDX_MASK_LOW:   rd_value = {24'h00_0000, soft_event_mask_reg[6:0], 1'b0};
         mem_window_pkg::IDX_MASK_HIGH:  rd_value = {24'h00_0000, soft_event_mask_reg[14:7]};
         mem_window_pkg::IDX_IRQ_STATUS: rd_value = {29'h0000_0000, irq_status_reg};
         mem_window_pkg::IDX_IRQ_ENABLE: rd_value = {29'h0000_0000, irq_enable_reg};
         mem_window_pkg::IDX_ACCESS:     rd_value = {30'h0000_0000, access_type_reg};
         default:                        rd_value = 32'h0000_0000;
      endcase
   end

   // Read channel: one outstanding read, answered the cycle after acceptance
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= mem_window_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_value;
            s_axi_rresp  <= rd_hit ? mem_window_pkg::RESP_OKAY : mem_window_pkg::RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : mem_window_regs
